/* File: rtl/vmtu_vector_mask_test_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module vmtu_vector_mask_test_unit (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 issue_valid,
    input  wire vmtu_pkg::vmtu_cmd_s  issue_cmd,
    input  wire vmtu_pkg::vmtu_elem_s src_elem,
    output logic                      issue_ready,
    output logic                      elem_take,
    output logic                      unit_busy,
    output logic                      src_release,
    output logic                      mask_ready,
    output logic                      mask_xfer_ready,
    output logic [63:0]               element_mask_reg
);
    import vmtu_pkg::*;

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    vmtu_state_e      state_reg;
    vmtu_state_e      state_next;
    vmtu_state_e      start_state;
    logic             in_idle;
    logic             in_test;
    logic             in_tail;
    logic             in_done;
    logic [1:0]       test_reg;
    logic [1:0]       test_next;
    logic [LEN_W-1:0] element_count_reg;
    logic [LEN_W-1:0] element_count_next;
    logic [LEN_W-1:0] index_reg;
    logic [LEN_W-1:0] index_next;
    logic [LEN_W-1:0] index_plus;
    logic [7:0]       tail_reg;
    logic [7:0]       tail_next;
    logic [63:0]      mask_next;
    logic [63:0]      bit_write;
    logic             elem_zero;
    logic             elem_sign;
    logic             elem_hit;
    logic             issue_take;
    logic             last_elem;
    logic             rel_hit;
    logic             rdy_hit;
    logic             src_rel_reg;
    logic             src_rel_next;
    logic             rdy_reg;
    logic             rdy_next;
    logic             xfer_reg;
    logic             xfer_next;

    // ----------------------------------------------------------------
    // state decode and handshake
    // ----------------------------------------------------------------
    assign in_idle     = (state_reg == VMTU_IDLE);
    assign in_test     = (state_reg == VMTU_TEST);
    assign in_tail     = (state_reg == VMTU_TAIL);
    assign in_done     = (state_reg == VMTU_DONE);
    assign issue_ready = in_idle || in_done;
    assign unit_busy   = ~issue_ready;
    assign issue_take  = issue_valid && issue_ready;
    assign elem_take   = in_test && src_elem.valid;

    // ----------------------------------------------------------------
    // element test
    // ----------------------------------------------------------------
    assign elem_zero = (src_elem.data == 64'h0);
    assign elem_sign = src_elem.data[SIGN_BIT];

    always_comb begin
        case (test_reg)
            TEST_ZERO: begin
                elem_hit = elem_zero;
            end
            TEST_NONZERO: begin
                elem_hit = ~elem_zero;
            end
            TEST_POSITIVE: begin
                elem_hit = ~elem_sign;
            end
            TEST_NEGATIVE: begin
                elem_hit = elem_sign;
            end
            default: begin
                elem_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // command capture
    // ----------------------------------------------------------------
    always_comb begin
        test_next          = test_reg;
        element_count_next = element_count_reg;
        if (issue_take) begin
            test_next          = issue_cmd.test_sel[1:0];
            element_count_next = issue_cmd.elem_count;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            test_reg          <= TEST_ZERO;
            element_count_reg <= LEN_RESET;
        end else begin
            test_reg          <= test_next;
            element_count_reg <= element_count_next;
        end
    end

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    // an empty vector goes straight to the tail count
    always_comb begin
        if (issue_cmd.elem_count == LEN_RESET) begin
            start_state = VMTU_TAIL;
        end else begin
            start_state = VMTU_TEST;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            VMTU_IDLE: begin
                if (issue_take) begin
                    state_next = start_state;
                end
            end
            VMTU_TEST: begin
                if (last_elem) begin
                    state_next = VMTU_TAIL;
                end
            end
            VMTU_TAIL: begin
                if (rdy_hit) begin
                    state_next = VMTU_DONE;
                end
            end
            VMTU_DONE: begin
                if (issue_take) begin
                    state_next = start_state;
                end else begin
                    state_next = VMTU_IDLE;
                end
            end
            default: begin
                state_next = VMTU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= VMTU_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // element index
    // ----------------------------------------------------------------
    assign index_plus = LEN_W'(index_reg + 7'h1);
    assign last_elem  = elem_take && (index_plus == element_count_reg);

    always_comb begin
        index_next = index_reg;
        if (issue_take) begin
            index_next = LEN_RESET;
        end else if (elem_take) begin
            index_next = index_plus;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            index_reg <= LEN_RESET;
        end else begin
            index_reg <= index_next;
        end
    end

    // ----------------------------------------------------------------
    // tail count
    // ----------------------------------------------------------------
    // counts periods after the last element; the issue period is already spent
    assign rel_hit = in_tail && (tail_reg == 8'(SRC_FREE_CP - ISSUE_CP - 1));
    assign rdy_hit = in_tail && (tail_reg == 8'(MASK_RDY_CP - ISSUE_CP - 1));

    always_comb begin
        tail_next = tail_reg;
        if (issue_take) begin
            tail_next = TAIL_RESET;
        end else if (in_tail) begin
            tail_next = 8'(tail_reg + 8'h1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tail_reg <= TAIL_RESET;
        end else begin
            tail_reg <= tail_next;
        end
    end

    // ----------------------------------------------------------------
    // source release pulse
    // ----------------------------------------------------------------
    always_comb begin
        src_rel_next = rel_hit;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_rel_reg <= 1'b0;
        end else begin
            src_rel_reg <= src_rel_next;
        end
    end

    // ----------------------------------------------------------------
    // general mask ready
    // ----------------------------------------------------------------
    always_comb begin
        rdy_next = rdy_reg;
        if (issue_take) begin
            rdy_next = 1'b0;
        end else if (rdy_hit) begin
            rdy_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdy_reg <= 1'b0;
        end else begin
            rdy_reg <= rdy_next;
        end
    end

    // ----------------------------------------------------------------
    // transfer mask ready
    // ----------------------------------------------------------------
    // one period behind the general ready; a new issue in done suppresses it
    always_comb begin
        xfer_next = xfer_reg;
        if (issue_take) begin
            xfer_next = 1'b0;
        end else if (in_done) begin
            xfer_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xfer_reg <= 1'b0;
        end else begin
            xfer_reg <= xfer_next;
        end
    end

    // ----------------------------------------------------------------
    // mask bits
    // ----------------------------------------------------------------
    // bit b holds the result of element NUM_ELEM-1-b
    for (genvar b = 0; b < NUM_ELEM; b++) begin : g_mask_bit
        logic bit_value;
        assign bit_write[b] = elem_take && (index_reg[5:0] == 6'(NUM_ELEM - 1 - b));
        always_comb begin
            if (issue_take) begin
                bit_value = MASK_RESET[b];
            end else if (bit_write[b]) begin
                bit_value = elem_hit;
            end else begin
                bit_value = element_mask_reg[b];
            end
        end
        assign mask_next[b] = bit_value;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            element_mask_reg <= MASK_RESET;
        end else begin
            element_mask_reg <= mask_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign src_release     = src_rel_reg;
    assign mask_ready      = rdy_reg;
    assign mask_xfer_ready = xfer_reg;
endmodule : vmtu_vector_mask_test_unit
`default_nettype wire

/* File: include/vmtu_pkg.sv */
package vmtu_pkg;
    localparam int          ELEM_W        = 64;
    localparam int          NUM_ELEM      = 64;
    localparam int          LEN_W         = 7;
    localparam int          SEL_W         = 3;
    localparam int          SIGN_BIT      = 63;
    localparam logic [1:0]  TEST_ZERO     = 2'h0;
    localparam logic [1:0]  TEST_NONZERO  = 2'h1;
    localparam logic [1:0]  TEST_POSITIVE = 2'h2;
    localparam logic [1:0]  TEST_NEGATIVE = 2'h3;
    localparam int          ISSUE_CP      = 1;
    localparam int          SRC_FREE_CP   = 3;
    localparam int          MASK_RDY_CP   = 4;
    localparam int          MASK_XFER_CP  = 5;
    localparam logic [63:0] MASK_RESET    = 64'h0;
    localparam logic [6:0]  LEN_RESET     = 7'h0;
    localparam logic [7:0]  TAIL_RESET    = 8'h0;

    typedef struct packed {
        logic [SEL_W-1:0] test_sel;
        logic [LEN_W-1:0] elem_count;
    } vmtu_cmd_s;

    typedef struct packed {
        logic              valid;
        logic [ELEM_W-1:0] data;
    } vmtu_elem_s;

    typedef enum logic [3:0] {
        VMTU_IDLE = 4'b0001,
        VMTU_TEST = 4'b0010,
        VMTU_TAIL = 4'b0100,
        VMTU_DONE = 4'b1000
    } vmtu_state_e;
endpackage : vmtu_pkg

/* File: verification/vmtu_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module vmtu_properties (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire logic                 issue_valid,
    input wire vmtu_pkg::vmtu_elem_s src_elem,
    input wire logic                 issue_ready,
    input wire logic                 elem_take,
    input wire logic                 unit_busy,
    input wire logic                 src_release,
    input wire logic                 mask_ready,
    input wire logic                 mask_xfer_ready,
    input wire logic [63:0]          element_mask_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence issued; issue_valid && issue_ready; endsequence
    sequence rel_then_ready; src_release ##1 (!src_release && mask_ready); endsequence
    busy_flag_a: assert property (unit_busy |-> !mask_ready && !mask_xfer_ready)
        else $error("busy flag");
    busy_end_a: assert property ($fell(unit_busy) |-> mask_ready) else $error("busy end");
    issue_clear_a: assert property (issued |=> !mask_ready && !mask_xfer_ready
        && !issue_ready && element_mask_reg == 64'h0) else $error("issue clear");
    take_valid_a: assert property (elem_take |-> src_elem.valid && !issue_ready) else $error("take");
    release_order_a: assert property (src_release |-> rel_then_ready) else $error("release");
    release_wait_a: assert property (issued |=> !src_release [*2]) else $error("early release");
    ready_cause_a: assert property ($rose(mask_ready) |-> $past(src_release) && issue_ready)
        else $error("ready cause");
    xfer_follow_a: assert property ($rose(mask_ready) && !(issue_valid && issue_ready)
        |=> mask_xfer_ready) else $error("xfer late");
    xfer_cause_a: assert property ($rose(mask_xfer_ready) |-> $past(mask_ready) && mask_ready)
        else $error("xfer early");
    mask_hold_a: assert property (mask_ready && $past(mask_ready) |-> $stable(element_mask_reg))
        else $error("mask moved");
endmodule : vmtu_properties
bind vmtu_vector_mask_test_unit vmtu_properties chk (.clk, .reset_n, .issue_valid, .src_elem, .issue_ready,
    .elem_take, .unit_busy, .src_release, .mask_ready, .mask_xfer_ready, .element_mask_reg);
`default_nettype wire

/* File: verification/vmtu_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vmtu_src_model (
    input wire logic             clk,
    input wire logic             elem_take,
    input wire logic             restart,
    input wire logic             stall,
    output var vmtu_pkg::vmtu_elem_s src_elem
);
    logic [63:0] mem [64];
    logic [6:0]  idx = 7'h0;
    logic [7:0]  lfsr = 8'h5a;
    // elements in order; a stalled slot shows inverted data
    always @(posedge clk) begin
        if (restart) idx = 7'h0;
        else if (elem_take) idx = idx + 7'h1;
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        src_elem.valid <= !stall || lfsr[0];
        src_elem.data <= mem[idx[5:0]] ^ {64{stall && !lfsr[0]}};
    end
endmodule : vmtu_src_model
`default_nettype wire

/* File: verification/vector_mask_test_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module vector_mask_test_unit_tb;
    import vmtu_pkg::*;
    logic clk = 0, reset_n = 0, issue_valid = 0, stall = 0;
    logic issue_ready, elem_take, unit_busy, src_release, mask_ready, mask_xfer_ready;
    logic [63:0] mask;
    logic [31:0] seed = 32'hce47;
    vmtu_cmd_s cmd = '0;
    vmtu_elem_s src_elem;
    int err_count = 0, checks_done = 0;
    vmtu_vector_mask_test_unit dut (.clk, .reset_n, .issue_valid, .issue_cmd(cmd), .src_elem, .issue_ready,
        .elem_take, .unit_busy, .src_release, .mask_ready, .mask_xfer_ready, .element_mask_reg(mask));
    vmtu_src_model src (.clk, .elem_take, .restart(issue_valid), .stall, .src_elem);
    initial forever #50 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [63:0] exp_mask(input logic [2:0] s, input int l);
        logic [63:0] m = 64'h0;
        for (int i = 0; i < l; i++) begin
            case (s[1:0])
                TEST_ZERO: m[63-i] = src.mem[i] == 64'h0;
                TEST_NONZERO: m[63-i] = src.mem[i] != 64'h0;
                TEST_POSITIVE: m[63-i] = !src.mem[i][SIGN_BIT];
                default: m[63-i] = src.mem[i][SIGN_BIT];
            endcase
        end
        return m;
    endfunction : exp_mask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("mismatches %0d in %0d checks", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic run(input logic [2:0] s, input int l, input logic st);
        int n = 0;
        int rel = 0;
        for (int i = 0; i < 64; i++) src.mem[i] = rnd() % 3 == 0 ? 64'h0 : {rnd(), rnd()};
        stall = st;
        cmd = {s, 7'(l)};
        check(64'({issue_ready, unit_busy}), 64'h2);
        issue_valid = 1;
        @(negedge clk);
        issue_valid = 0;
        while (!mask_ready && n < 300) begin
            @(negedge clk);
            n++;
            if (src_release) rel = n;
        end
        check(64'(n < 300), 64'h1);
        check(mask, exp_mask(s, l));
        check(64'(mask_xfer_ready), 64'h0);
        check(64'(rel), 64'(n - MASK_RDY_CP + SRC_FREE_CP));
        if (!st) begin
            check({rel + ISSUE_CP, n + ISSUE_CP}, {l + SRC_FREE_CP, l + MASK_RDY_CP});
        end
        @(negedge clk);
        check(64'(mask_xfer_ready), 64'h1);
    endtask : run
    initial begin
        repeat (5) @(negedge clk);
        check(mask, MASK_RESET);
        check(64'({issue_ready, mask_ready, mask_xfer_ready, src_release}), 64'h8);
        reset_n = 1;
        for (int s = 0; s < 8; s++) run(3'(s), (s * 9) % 65, s[0]);
        run(3'h4, 64, 0);
        run(3'h1, 1, 0);
        repeat (40) run(3'(rnd()), int'(rnd() % 65), 1'(rnd()));
        give_verdict();
    end
    initial begin
        #3000000;
        err_count++;
        give_verdict();
    end
endmodule : vector_mask_test_unit_tb
`default_nettype wire
